// ===== rtl/atpg_regs.svh
// Functional notes
// - While a test code is selected the converter samples are cut off and the pattern goes to the formatter.
// - The pattern is picked by a four-bit code held in the writable test mode register at 0x550.
// - Setting bit 4 or bit 5 of the test mode register holds the pseudorandom generators at their seeds.
// - Patterns are made without regard to the analog input and advance only on sample clock enables.
// - Downconverter in-phase test data carries the channel A pattern and quadrature carries channel B.
// - The fourth downconverter takes channel A on in-phase and never injects on quadrature.
// - Code 0100 alternates 0x1555 and 0x2AAA on successive samples.
// - Code 0101 gives the long sequence x^23+x^18+1 seeded with 0x3AFF.
// - Code 0110 gives the short sequence x^9+x^5+1 seeded with 0x0092.
// - Code 0111 alternates 0x0000 and 0x3FFF on successive samples.
// - Code 1000 plays user words one to four (bits 15:2), then repeats or holds zero in single mode.
// - Code 1111 is a ramp that adds one per sample and wraps at 2^14.
`ifndef ATPG_REGS_SVH
`define ATPG_REGS_SVH

`define ATPG_ADDR_DDC0_CTL  12'h327
`define ATPG_ADDR_DDC1_CTL  12'h347
`define ATPG_ADDR_DDC2_CTL  12'h367
`define ATPG_ADDR_FOURTH_DOWNCONVERTER_CTL  12'h387
`define ATPG_ADDR_MODE      12'h550
`define ATPG_ADDR_USER_LO   12'h551
`define ATPG_ADDR_USER_HI   12'h558

`define ATPG_DDC_EN_BIT0    0
`define ATPG_DDC_EN_BIT2    2
`define ATPG_MODE_CODE_MSB  3
`define ATPG_PN_LONG_RST    4
`define ATPG_PN_SHORT_RST   5
`define ATPG_USER_SINGLE    6
`define ATPG_REG_RESET      8'h00

`define ATPG_MIDSCALE       14'h0000
`define ATPG_POS_FULL       14'h1FFF
`define ATPG_NEG_FULL       14'h2000
`define ATPG_CHECK_A        14'h1555
`define ATPG_CHECK_B        14'h2AAA
`define ATPG_ALL_ZERO       14'h0000
`define ATPG_ALL_ONE        14'h3FFF
`define ATPG_LONG_SEED      23'h3AFF
`define ATPG_SHORT_SEED     23'h0092
`define ATPG_LONG_LEN       23
`define ATPG_LONG_TAP       18
`define ATPG_SHORT_LEN      9
`define ATPG_SHORT_TAP      5
`define ATPG_FIFO_DEPTH     8

`endif

// ===== rtl/atpg_pkg.sv
package atpg_pkg;

  typedef logic [13:0] atpg_sample_t;

  typedef enum logic [3:0] {
    ATPG_OFF      = 4'h0,
    ATPG_MID      = 4'h1,
    ATPG_POSFS    = 4'h2,
    ATPG_NEGFS    = 4'h3,
    ATPG_CHECKER  = 4'h4,
    ATPG_PN_LONG  = 4'h5,
    ATPG_PN_SHORT = 4'h6,
    ATPG_TOGGLE   = 4'h7,
    ATPG_USER     = 4'h8,
    ATPG_RAMP     = 4'hF
  } atpg_code_t;

endpackage : atpg_pkg

// ===== rtl/atpg_top.sv
`timescale 1ns/10ps
`include "atpg_regs.svh"

////////////////////////////////////////////////////////////////////////////////
// shift-register fifo, head word always in a flop
module atpg_fifo #(
  parameter int WIDTH = 28,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [CW-1:0]    count_ff;
  logic [CW-1:0]    nxt_count;
  logic             ready_ff;
  logic             valid_ff;
  logic             push;
  logic             pop;

  assign push      = in_valid && ready_ff;
  assign pop       = valid_ff && out_ready;
  assign in_ready  = ready_ff;
  assign out_valid = valid_ff;
  assign out_data  = mem_ff[0];

  always_comb begin
    nxt_count = count_ff;
    if (push && !pop) begin
      nxt_count = count_ff + CW'(1);
    end else if (pop && !push) begin
      nxt_count = count_ff - CW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      count_ff <= '0;
      ready_ff <= 1'b1;
      valid_ff <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      ready_ff <= (nxt_count < CW'(DEPTH));
      valid_ff <= (nxt_count != '0);
    end
  end

  // storage: shift down on pop, write at the tail slot
  always_ff @(posedge clk) begin
    if (!rstn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_ff[i] <= '0;
      end
    end else begin
      for (int i = 0; i < DEPTH; i++) begin
        if (push && (pop ? (CW'(i) == count_ff - CW'(1)) : (CW'(i) == count_ff))) begin
          mem_ff[i] <= in_data;
        end else if (pop && i < DEPTH - 1) begin
          mem_ff[i] <= mem_ff[i+1];
        end
      end
    end
  end
endmodule : atpg_fifo

////////////////////////////////////////////////////////////////////////////////
// converter test pattern source with register map and ddc injection
module atpg_top (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    rstn,
  // register port
  input  wire logic [11:0]             reg_addr,
  input  wire logic                    reg_wr,
  input  wire logic [7:0]              reg_wdata,
  input  wire logic                    reg_rd,
  output logic      [7:0]              reg_rdata,
  // converter samples and sample clock enable
  input  wire logic                    sample_en,
  input  wire atpg_pkg::atpg_sample_t  adc_a_in,
  input  wire atpg_pkg::atpg_sample_t  adc_b_in,
  // stream toward output formatting
  output logic                         fmt_valid,
  input  wire logic                    fmt_ready,
  output atpg_pkg::atpg_sample_t       fmt_a_out,
  output atpg_pkg::atpg_sample_t       fmt_b_out,
  output logic                         test_active,
  // downconverter injection
  output atpg_pkg::atpg_sample_t       ddc_i_pat,
  output atpg_pkg::atpg_sample_t       ddc_q_pat,
  output logic      [3:0]              ddc_i_inject,
  output logic      [3:0]              ddc_q_inject
);
  import atpg_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // register file
  logic [7:0]  ddc_ctl_ff [4];
  logic [7:0]  mode_ff;
  logic [7:0]  user_byte_ff [8];
  logic [7:0]  rdata_ff;
  logic        mode_wr;

  function automatic logic [2:0] user_index(input logic [11:0] addr);
    logic [11:0] off;
    off = addr - `ATPG_ADDR_USER_LO;
    return off[2:0];
  endfunction : user_index

  function automatic logic is_user(input logic [11:0] addr);
    return (addr >= `ATPG_ADDR_USER_LO) && (addr <= `ATPG_ADDR_USER_HI);
  endfunction : is_user

  function automatic logic [1:0] ddc_index(input logic [11:0] addr);
    case (addr)
      `ATPG_ADDR_DDC1_CTL: ddc_index = 2'd1;
      `ATPG_ADDR_DDC2_CTL: ddc_index = 2'd2;
      `ATPG_ADDR_FOURTH_DOWNCONVERTER_CTL: ddc_index = 2'd3;
      default:             ddc_index = 2'd0;
    endcase
  endfunction : ddc_index

  function automatic logic is_ddc(input logic [11:0] addr);
    return addr == `ATPG_ADDR_DDC0_CTL || addr == `ATPG_ADDR_DDC1_CTL ||
           addr == `ATPG_ADDR_DDC2_CTL || addr == `ATPG_ADDR_FOURTH_DOWNCONVERTER_CTL;
  endfunction : is_ddc

  assign mode_wr = reg_wr && (reg_addr == `ATPG_ADDR_MODE);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      mode_ff <= `ATPG_REG_RESET;
    end else if (mode_wr) begin
      mode_ff <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      for (int i = 0; i < 4; i++) begin
        ddc_ctl_ff[i] <= `ATPG_REG_RESET;
      end
    end else if (reg_wr && is_ddc(reg_addr)) begin
      ddc_ctl_ff[ddc_index(reg_addr)] <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      for (int i = 0; i < 8; i++) begin
        user_byte_ff[i] <= `ATPG_REG_RESET;
      end
    end else if (reg_wr && is_user(reg_addr)) begin
      user_byte_ff[user_index(reg_addr)] <= reg_wdata;
    end
  end

  // unmapped reads return zero
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdata_ff <= '0;
    end else if (reg_rd) begin
      if (reg_addr == `ATPG_ADDR_MODE) begin
        rdata_ff <= mode_ff;
      end else if (is_user(reg_addr)) begin
        rdata_ff <= user_byte_ff[user_index(reg_addr)];
      end else if (is_ddc(reg_addr)) begin
        rdata_ff <= ddc_ctl_ff[ddc_index(reg_addr)];
      end else begin
        rdata_ff <= '0;
      end
    end
  end

  assign reg_rdata = rdata_ff;

  //////////////////////////////////////////////////////////////////////////////
  // pattern generators
  atpg_code_t  code;
  logic        step;
  logic        fifo_in_ready;
  logic        phase_ff;
  logic [13:0] ramp_ff;
  logic [2:0]  user_ptr_ff;
  logic [22:0] pn_long_ff;
  logic [22:0] pn_short_ff;
  logic [13:0] pn_long_word;
  logic [13:0] pn_short_word;
  logic [22:0] nxt_pn_long;
  logic [22:0] nxt_pn_short;
  logic [13:0] user_word;
  logic [15:0] user_full;
  logic [13:0] pattern;
  logic        testing;

  assign code    = atpg_code_t'(mode_ff[`ATPG_MODE_CODE_MSB:0]);
  assign testing = (code != ATPG_OFF);
  // a sample is produced on each sample clock enable while the fifo accepts
  assign step    = sample_en && fifo_in_ready;

  // runs len-bit lfsr for 14 shifts, state leaves lsb first, first bit lands in the word msb
  function automatic logic [36:0] pn_run(input logic [22:0] st, input int len,
                                         input int tap);
    logic [22:0] s;
    logic [13:0] w;
    logic        fb;
    s = st;
    w = '0;
    for (int k = 0; k < 14; k++) begin
      fb       = s[0] ^ s[len-tap];
      w        = {w[12:0], s[0]};
      s        = s >> 1;
      s[len-1] = fb;
    end
    return {w, s};
  endfunction : pn_run

  assign {pn_long_word, nxt_pn_long}   = pn_run(pn_long_ff, `ATPG_LONG_LEN, `ATPG_LONG_TAP);
  assign {pn_short_word, nxt_pn_short} = pn_run(pn_short_ff, `ATPG_SHORT_LEN,
                                                `ATPG_SHORT_TAP);

  always_ff @(posedge clk) begin
    if (!rstn || mode_ff[`ATPG_PN_LONG_RST] || mode_ff[`ATPG_PN_SHORT_RST]) begin
      pn_long_ff <= `ATPG_LONG_SEED;
    end else if (step && code == ATPG_PN_LONG) begin
      pn_long_ff <= nxt_pn_long;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn || mode_ff[`ATPG_PN_LONG_RST] || mode_ff[`ATPG_PN_SHORT_RST]) begin
      pn_short_ff <= `ATPG_SHORT_SEED;
    end else if (step && code == ATPG_PN_SHORT) begin
      pn_short_ff <= nxt_pn_short;
    end
  end

  // phase, ramp and user word positions restart whenever the mode register is written; the pn generators do not
  always_ff @(posedge clk) begin
    if (!rstn || mode_wr) begin
      phase_ff <= 1'b0;
    end else if (step) begin
      phase_ff <= ~phase_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn || mode_wr) begin
      ramp_ff <= '0;
    end else if (step && code == ATPG_RAMP) begin
      ramp_ff <= ramp_ff + 14'h0001;
    end
  end

  // pointer value 4 means single mode has run out
  always_ff @(posedge clk) begin
    if (!rstn || mode_wr) begin
      user_ptr_ff <= '0;
    end else if (step && code == ATPG_USER) begin
      if (user_ptr_ff == 3'd3) begin
        user_ptr_ff <= mode_ff[`ATPG_USER_SINGLE] ? 3'd4 : 3'd0;
      end else if (user_ptr_ff != 3'd4) begin
        user_ptr_ff <= user_ptr_ff + 3'd1;
      end
    end
  end

  always_comb begin
    user_full = {user_byte_ff[{user_ptr_ff[1:0], 1'b1}],
                 user_byte_ff[{user_ptr_ff[1:0], 1'b0}]};
    user_word = (user_ptr_ff == 3'd4) ? 14'h0000 : user_full[15:2];
  end

  always_comb begin
    case (code)
      ATPG_MID:      pattern = `ATPG_MIDSCALE;
      ATPG_POSFS:    pattern = `ATPG_POS_FULL;
      ATPG_NEGFS:    pattern = `ATPG_NEG_FULL;
      ATPG_CHECKER:  pattern = phase_ff ? `ATPG_CHECK_B : `ATPG_CHECK_A;
      ATPG_PN_LONG:  pattern = pn_long_word;
      ATPG_PN_SHORT: pattern = pn_short_word;
      ATPG_TOGGLE:   pattern = phase_ff ? `ATPG_ALL_ONE : `ATPG_ALL_ZERO;
      ATPG_USER:     pattern = user_word;
      ATPG_RAMP:     pattern = ramp_ff;
      default:       pattern = `ATPG_MIDSCALE;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // output path through the fifo
  atpg_sample_t src_a;
  atpg_sample_t src_b;
  logic [27:0]  fifo_out;

  // converter samples never reach the formatter while testing
  assign src_a = testing ? pattern : adc_a_in;
  assign src_b = testing ? pattern : adc_b_in;

  atpg_fifo #(
    .WIDTH (28),
    .DEPTH (`ATPG_FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rstn      (rstn),
    .in_valid  (sample_en),
    .in_ready  (fifo_in_ready),
    .in_data   ({src_a, src_b}),
    .out_valid (fmt_valid),
    .out_ready (fmt_ready),
    .out_data  (fifo_out)
  );

  assign fmt_a_out = fifo_out[27:14];
  assign fmt_b_out = fifo_out[13:0];

  //////////////////////////////////////////////////////////////////////////////
  // downconverter feed
  logic [13:0] ddc_i_ff;
  logic [13:0] ddc_q_ff;
  logic [3:0]  inj_i_ff;
  logic [3:0]  inj_q_ff;
  logic        active_ff;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ddc_i_ff <= '0;
      ddc_q_ff <= '0;
    end else if (step) begin
      ddc_i_ff <= src_a;
      ddc_q_ff <= src_b;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      inj_i_ff  <= '0;
      inj_q_ff  <= '0;
      active_ff <= 1'b0;
    end else begin
      active_ff <= testing;
      for (int i = 0; i < 4; i++) begin
        inj_i_ff[i] <= testing && ddc_ctl_ff[i][`ATPG_DDC_EN_BIT2]
                       && ddc_ctl_ff[i][`ATPG_DDC_EN_BIT0];
        inj_q_ff[i] <= testing && ddc_ctl_ff[i][`ATPG_DDC_EN_BIT2]
                       && ddc_ctl_ff[i][`ATPG_DDC_EN_BIT0] && (i != 3);
      end
    end
  end

  assign ddc_i_pat    = ddc_i_ff;
  assign ddc_q_pat    = ddc_q_ff;
  assign ddc_i_inject = inj_i_ff;
  assign ddc_q_inject = inj_q_ff;
  assign test_active  = active_ff;

endmodule : atpg_top

// ===== tb/atpg_checker.sv
`timescale 1ns/10ps
module atpg_checker (
  // clock and reset
  input wire logic                   clk,
  input wire logic                   rstn,
  // register port
  input wire logic [11:0]            reg_addr,
  input wire logic                   reg_wr,
  input wire logic [7:0]             reg_wdata,
  input wire logic                   reg_rd,
  input wire logic [7:0]             reg_rdata,
  // stream and injection
  input wire logic                   sample_en,
  input wire logic                   fmt_valid,
  input wire logic                   fmt_ready,
  input wire atpg_pkg::atpg_sample_t fmt_a_out,
  input wire atpg_pkg::atpg_sample_t fmt_b_out,
  input wire logic                   test_active,
  input wire logic [3:0]             ddc_i_inject,
  input wire logic [3:0]             ddc_q_inject
);
  import atpg_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  sequence s_mode_wr;
    reg_wr && reg_addr == 12'h550;
  endsequence
  sequence s_stall;
    fmt_valid && !fmt_ready;
  endsequence
  a_mode_on: assert property (s_mode_wr ##0 reg_wdata[3:0] != 4'h0
    |-> ##[1:2] test_active) else $error("test flag did not rise");
  a_mode_off: assert property (s_mode_wr ##0 reg_wdata[3:0] == 4'h0
    |-> ##[1:2] !test_active) else $error("test flag did not fall");
  a_q3_idle: assert property (!ddc_q_inject[3])
    else $error("fourth quadrature injected");
  a_inject_off: assert property (!test_active [*2]
    |-> ddc_i_inject == 4'h0 && ddc_q_inject == 4'h0) else $error("inject outside test");
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved");
  a_unmapped_zero: assert property (reg_rd && reg_addr == 12'h000
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  a_head_holds: assert property (s_stall |=> fmt_valid && $stable(fmt_a_out)
    && $stable(fmt_b_out)) else $error("stalled head changed");
  a_first_valid: assert property (sample_en && !fmt_valid |=> fmt_valid)
    else $error("sample not taken");
endmodule : atpg_checker
bind atpg_top atpg_checker i_chk (.*);

// ===== tb/atpg_fmt_model.sv
`timescale 1ns/10ps
module atpg_fmt_model (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rstn,
  // stream from pattern source
  input  wire logic                   fmt_valid,
  output logic                        fmt_ready,
  input  wire atpg_pkg::atpg_sample_t fmt_a_out,
  input  wire atpg_pkg::atpg_sample_t fmt_b_out,
  // pacing from bench
  input  wire logic                   stall,
  input  wire logic                   pace
);
  import atpg_pkg::*;
  atpg_sample_t qa[$];
  atpg_sample_t qb[$];
  assign fmt_ready = !stall && pace;
  always @(posedge clk) begin
    if (rstn && fmt_valid && fmt_ready) begin
      qa.push_back(fmt_a_out);
      qb.push_back(fmt_b_out);
    end
  end
endmodule : atpg_fmt_model

// ===== tb/atpg_top_tb.sv
`timescale 1ns/10ps
module atpg_top_tb;
  import atpg_pkg::*;
  logic         clk, rstn, reg_wr, reg_rd, sample_en, fmt_valid, fmt_ready;
  logic         test_active, stall, pace;
  logic [11:0]  reg_addr;
  logic [7:0]   reg_wdata, reg_rdata;
  logic [3:0]   ddc_i_inject, ddc_q_inject;
  atpg_sample_t adc_a_in, adc_b_in, fmt_a_out, fmt_b_out, ddc_i_pat, ddc_q_pat;
  atpg_sample_t ea[$], eb[$];
  logic [15:0]  up[4];
  atpg_sample_t pn_l[3] = '{14'h3FD7, 14'h0002, 14'h26E0};
  atpg_sample_t pn_s[3] = '{14'h125B, 14'h3C9A, 14'h2660};
  logic [7:0]   codes[11] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h07, 8'h08, 8'h48,
                              8'h0F, 8'h35, 8'h26, 8'h00};
  integer       seed = 79;
  integer       num_errors = 0;
  integer       n_tests = 0;
  integer       cyc = 0;

  atpg_top i_dut (.*);
  atpg_fmt_model i_fmt (.*);

  ////////////////////////////////////////
  task finish_test;
    if (num_errors == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk

  function automatic atpg_sample_t pat(input logic [7:0] m, input int k);
    case (m[3:0])
      4'h2: return 14'h1FFF;
      4'h3: return 14'h2000;
      4'h4: return (k % 2) ? 14'h2AAA : 14'h1555;
      4'h5: return (m[5:4] != 2'b00) ? 14'h3FD7 : pn_l[k];
      4'h6: return (m[5:4] != 2'b00) ? 14'h125B : pn_s[k];
      4'h7: return (k % 2) ? 14'h3FFF : 14'h0000;
      4'h8: return (k > 3 && m[6]) ? 14'h0000 : up[k % 4][15:2];
      4'hF: return k[13:0];
      default: return 14'h0000;
    endcase
  endfunction : pat

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    @(negedge clk) reg_wr = 0;
    @(negedge clk);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    reg_addr = a;
    reg_rd = 1;
    @(negedge clk) reg_rd = 0;
    @(negedge clk) chk(16'(reg_rdata), 16'(e));
  endtask : rd

  task automatic drain(input logic [7:0] m, input int n);
    for (int t = 0; t < 300 && i_fmt.qa.size() < n; t++) @(negedge clk);
    chk(16'(i_fmt.qa.size()), 16'(n));
    for (int k = 0; k < n && k < i_fmt.qa.size(); k++) begin
      chk(16'(i_fmt.qa[k]), 16'(ea[k]));
      chk(16'(i_fmt.qb[k]), 16'(eb[k]));
    end
    chk(16'(ddc_i_pat), 16'(ea[n-1]));
    chk(16'(ddc_q_pat), 16'(eb[n-1]));
    i_fmt.qa.delete();
    i_fmt.qb.delete();
    ea.delete();
    eb.delete();
  endtask : drain

  // k0 above zero continues the running pattern without a mode write
  task automatic run(input logic [7:0] m, input int n, input int k0);
    if (k0 == 0) wr(12'h550, m);
    for (int k = 0; k < n; k++) begin
      adc_a_in = 14'($random(seed));
      adc_b_in = 14'($random(seed));
      ea.push_back(m[3:0] == 4'h0 ? adc_a_in : pat(m, k0 + k));
      eb.push_back(m[3:0] == 4'h0 ? adc_b_in : pat(m, k0 + k));
      sample_en = 1;
      @(negedge clk) sample_en = 0;
      repeat (2) @(negedge clk);
    end
    drain(m, n);
  endtask : run

  ////////////////////////////////////////
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end

  always @(negedge clk) pace <= ($random(seed) % 4) != 0;

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      num_errors++;
      finish_test();
    end
  end

  initial begin
    rstn = 0;
    reg_wr = 0;
    reg_rd = 0;
    reg_addr = 0;
    reg_wdata = 0;
    sample_en = 0;
    adc_a_in = 0;
    adc_b_in = 0;
    stall = 0;
    repeat (3) @(negedge clk);
    rstn = 1;
    @(negedge clk);
    rd(12'h550, 8'h00);
    rd(12'h387, 8'h00);
    for (int n = 0; n < 8; n++) begin
      up[n/2][8*(n%2)+:8] = 8'($random(seed));
      wr(12'h551 + 12'(n), up[n/2][8*(n%2)+:8]);
    end
    for (int n = 0; n < 8; n++) rd(12'h551 + 12'(n), up[n/2][8*(n%2)+:8]);
    wr(12'h000, 8'h5A);
    rd(12'h000, 8'h00);
    for (int d = 0; d < 4; d++) wr(12'h327 + 12'(32 * d), 8'h05);
    run(8'h04, 3, 0);
    chk(16'({ddc_q_inject, ddc_i_inject}), 16'h007F);
    wr(12'h347, 8'h01);
    run(8'h07, 3, 0);
    chk(16'({ddc_q_inject, ddc_i_inject}), 16'h005D);
    rd(12'h550, 8'h07);
    // full buffer drops extra samples and holds the pattern position
    stall = 1;
    wr(12'h550, 8'h04);
    sample_en = 1;
    repeat (10) @(negedge clk);
    sample_en = 0;
    for (int k = 0; k < 8; k++) begin
      ea.push_back(pat(8'h04, k));
      eb.push_back(pat(8'h04, k));
    end
    stall = 0;
    drain(8'h04, 8);
    run(8'h04, 2, 8);
    run(8'h05, 3, 0);
    run(8'h06, 3, 0);
    foreach (codes[i]) run(codes[i], 10, 0);
    chk(16'({test_active, ddc_q_inject, ddc_i_inject}), 16'h0000);
    finish_test();
  end
endmodule : atpg_top_tb
